// [verilog/flash_status_defines.svh]
// Constants for the flash status and write-protect logic.
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH
// Command codes.
`define CMD_ARM 8'h06
`define CMD_DISARM 8'h04
`define CMD_RD_STAT 8'h05
`define CMD_WR_STAT 8'h01
`define CMD_PAGE 8'h02
`define CMD_SECT 8'h20
`define CMD_BLOCK 8'hd8
`define CMD_CHIP_A 8'hc7
`define CMD_CHIP_B 8'h60
`define CMD_SLEEP 8'hb9
`define CMD_WAKE 8'hab
// Status word bit positions.
`define ST_BUSY 0
`define ST_ARM 1
`define ST_BP_LO 2
`define ST_BP_HI 5
`define ST_LOCK 7
// Synchroniser lanes.
`define PIN_SCK 0
`define PIN_CS 1
`define PIN_SI 2
`define PIN_WP 3
`define PIN_W 4
// Byte counts and bit and byte indices of command sequences.
`define LEN_CMD 3'h1
`define LEN_STAT 3'h2
`define LEN_ADDR 3'h4
`define BIT_LAST 3'h7
`define BYTE_ADDR_LO 3'h3
// Protect field decode.
`define BLOCKS_ALL 4'h8
`define NB_0 4'h0
`define NB_1 4'h1
`define NB_2 4'h2
`define NB_4 4'h4
`define LIM_9 8'h7e
`define LIM_10 8'h7c
`define LIM_11 8'h78
`define LIM_12 8'h70
`define LIM_13 8'h60
`define LIM_14 8'h40
`define LIM_15 8'h80
`define LIM_0 8'h00
`endif

// [verilog/flash_status_pkg.sv]
// Types shared by the flash status and write-protect logic.
package flash_status_pkg;
    // Kind of internal operation handed to the array engine.
    typedef enum logic [2:0] {
        OP_PAGE = 3'b000,
        OP_SECT = 3'b001,
        OP_BLOCK = 3'b010,
        OP_CHIP = 3'b011,
        OP_STAT = 3'b100
    } op_kind_t;
endpackage

// [verilog/flash_status_wp.sv]
// Serial flash status word, write arming and array protection checks.
//
// Behaviour
// [RULE_01] Bit 0 busy; commands ignored while busy.
// [RULE_02] Bit 1 arm latch gates modifying commands.
// [RULE_03] Arm command sets the arm latch.
// [RULE_04] Disarm command clears the arm latch.
// [RULE_05] Successful operation completion clears arm latch.
// [RULE_06] Arm latch reads zero after reset.
// [RULE_07] Bits 5..2 protect field shield regions.
// [RULE_08] Chip wipe only with zero protect field.
// [RULE_09] Protect field starts all zeros.
// [RULE_10] Bit 6 reserved, always reads zero.
// [RULE_11] Bit 7 lock; clear means pin ignored.
// [RULE_12] Lock set and pin low rejects writes.
// [RULE_13] Modifying commands need whole-byte clock counts.
// [RULE_14] Host arms before every modifying command.
// [RULE_15] Power-down ignores all but wake command.
// [RULE_16] Top-bit-clear field protects upper blocks.
// [RULE_17] Top-bit-set field protects lower sectors.
// [RULE_18] Page write stays in page, 1-to-0.
// [RULE_19] Page write is code, address, data.
// [RULE_20] Wipes set addressed region to all ones.
// [RULE_21] First byte after select is command, MSB first.
// [RULE_22] Status read repeats until deselect.
// [RULE_23] Status write touches only protect and lock.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_defines.svh"
module flash_status_wp
    import flash_status_pkg::*;
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Serial pins from the host.
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    // Serial output pin.
    output logic so_out,
    output logic so_oe_out,
    // Array engine side.
    output logic op_start_out,
    output op_kind_t op_kind_out,
    output logic [23:0] op_addr_out,
    input wire logic op_done_in,
    output logic data_valid_out,
    output logic [7:0] data_out,
    output logic [23:0] data_addr_out,
    // Live status word.
    output logic [7:0] status_out
);
    // Two-stage synchronisers plus one history stage for edges.
    logic [`PIN_W-1:0] meta_q;
    logic [`PIN_W-1:0] sync_q;
    logic [1:0] hist_q;
    // Serial receive state.
    logic [7:0] shift_q, shift_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d;
    logic [7:0] cmd_q, cmd_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] col_q, col_d;
    logic [7:0] pend_q, pend_d;
    // Status fields.
    logic busy_q, busy_d;
    logic wel_q, wel_d;
    logic [3:0] bp_q, bp_d;
    logic lock_q, lock_d;
    logic sleep_q, sleep_d;
    // Output registers.
    logic so_q, so_d;
    logic oe_q, oe_d;
    logic start_q, start_d;
    op_kind_t kind_q, kind_d;
    logic [23:0] oaddr_q, oaddr_d;
    logic dv_q, dv_d;
    logic [7:0] db_q, db_d;
    logic [23:0] da_q, da_d;
    // Decoded helpers.
    logic sck_rise, sck_fall, cs_rise, sel;
    logic [7:0] stat_w;
    logic [7:0] sh_new;
    logic unlocked, page_ok;
    // Returns one when the given 4 kB sector is shielded by the field.
    function automatic logic prot_hit(input logic [6:0] sec,
                                      input logic [3:0] bp);
        logic [3:0] nb;
        logic [7:0] lim;
        case (bp[2:0])
            3'h0: nb = `NB_0;
            3'h1: nb = `NB_1;
            3'h2: nb = `NB_2;
            3'h3: nb = `NB_4;
            default: nb = `BLOCKS_ALL;
        endcase
        case (bp[2:0])
            3'h1: lim = `LIM_9;
            3'h2: lim = `LIM_10;
            3'h3: lim = `LIM_11;
            3'h4: lim = `LIM_12;
            3'h5: lim = `LIM_13;
            3'h6: lim = `LIM_14;
            3'h7: lim = `LIM_15;
            default: lim = `LIM_0;
        endcase
        if (bp[3]) begin
            // Low sectors from zero up to one below the limit are shielded.
            prot_hit = ({1'b0, sec} < lim); // [RULE_17]
        end else begin
            // The top nb blocks are shielded.
            prot_hit = (({1'b0, sec[6:4]} + nb) >= `BLOCKS_ALL); // [RULE_16]
        end
    endfunction
    // Pins cross into the clock domain; only stage two and the history stage are read.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meta_q <= 4'h2;
            sync_q <= 4'h2;
            hist_q <= 2'h2;
        end else begin
            meta_q <= {wp_n_in, si_in, cs_n_in, sck_in};
            sync_q <= meta_q;
            hist_q <= {sync_q[`PIN_CS], sync_q[`PIN_SCK]};
        end
    end
    // Edge detection works on the settled copies only.
    assign sel = ~sync_q[`PIN_CS];
    assign sck_rise = sel & sync_q[`PIN_SCK] & ~hist_q[0];
    assign sck_fall = sel & ~sync_q[`PIN_SCK] & hist_q[0];
    assign cs_rise = sync_q[`PIN_CS] & ~hist_q[1];
    assign sh_new = {shift_q[6:0], sync_q[`PIN_SI]};
    // Reserved bit is a constant zero.
    assign stat_w = {lock_q, 1'b0, bp_q, wel_q, busy_q}; // [RULE_10]
    // The pin only matters once the lock bit is set.
    assign unlocked = ~lock_q | sync_q[`PIN_WP]; // [RULE_11] [RULE_12]
    // Page writes and data strobes need arming, idle and no shield.
    assign page_ok = wel_q & ~busy_q & ~sleep_q
                     & ~prot_hit(addr_q[18:12], bp_q); // [RULE_02] [RULE_07]
    // Next-state logic for the serial engine and the status fields.
    always_comb begin
        shift_d = shift_q;
        bit_d = bit_q;
        byte_d = byte_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        col_d = col_q;
        pend_d = pend_q;
        busy_d = busy_q;
        wel_d = wel_q;
        bp_d = bp_q;
        lock_d = lock_q;
        sleep_d = sleep_q;
        so_d = so_q;
        oe_d = 1'b0;
        start_d = 1'b0;
        kind_d = kind_q;
        oaddr_d = oaddr_q;
        dv_d = 1'b0;
        db_d = db_q;
        da_d = da_q;
        if (!sel) begin
            // Deselect resets the serial framing.
            bit_d = 3'h0;
            byte_d = 3'h0;
        end else if (sck_rise) begin
            // Bits arrive on rising edges, most significant first.
            shift_d = sh_new; // [RULE_21]
            bit_d = bit_q + 3'h1;
            if (bit_q == `BIT_LAST) begin
                if (byte_q < `LEN_ADDR) begin
                    byte_d = byte_q + 3'h1;
                end
                if (byte_q == 3'h0) begin
                    cmd_d = sh_new; // [RULE_21]
                end else if (byte_q < `LEN_ADDR) begin
                    addr_d = {addr_q[15:0], sh_new}; // [RULE_19]
                    if (byte_q == `LEN_CMD) begin
                        pend_d = sh_new;
                    end
                    if (byte_q == `BYTE_ADDR_LO) begin
                        col_d = sh_new;
                    end
                end else if (cmd_q == `CMD_PAGE && page_ok) begin
                    // Column wraps so data never leaves the page.
                    dv_d = 1'b1; // [RULE_18]
                    db_d = sh_new;
                    da_d = {addr_q[23:8], col_q}; // [RULE_18]
                    col_d = col_q + 8'h01;
                end
            end
        end
        // Status bits go out on falling edges, repeating each byte.
        if (sel && !sleep_q && cmd_q == `CMD_RD_STAT && byte_q != 3'h0) begin
            oe_d = 1'b1; // [RULE_22]
            if (sck_fall) begin
                so_d = stat_w[3'h7 - bit_q]; // [RULE_22]
            end
        end else begin
            so_d = 1'b0;
        end
        // Commands take effect when select is released.
        if (cs_rise) begin
            if (sleep_q) begin
                // Only the wake command is heard while asleep.
                if (cmd_q == `CMD_WAKE && byte_q != 3'h0) begin
                    sleep_d = 1'b0; // [RULE_15]
                end
            end else if (!busy_q && bit_q == 3'h0) begin // [RULE_01] [RULE_13]
                case (cmd_q)
                    `CMD_ARM, `CMD_DISARM: begin
                        // One whole byte only; the code itself picks set or clear.
                        if (byte_q == `LEN_CMD) begin
                            wel_d = (cmd_q == `CMD_ARM); // [RULE_03] [RULE_04]
                        end
                    end
                    `CMD_SLEEP: begin
                        if (byte_q == `LEN_CMD) begin
                            sleep_d = 1'b1;
                        end
                    end
                    `CMD_WR_STAT: begin
                        if (byte_q >= `LEN_STAT && wel_q && unlocked) begin // [RULE_12]
                            start_d = 1'b1;
                            kind_d = OP_STAT;
                            oaddr_d = {16'h0000, pend_q}; // [RULE_23]
                        end
                    end
                    `CMD_PAGE: begin
                        if (byte_q >= `LEN_ADDR && page_ok) begin // [RULE_18]
                            start_d = 1'b1;
                            kind_d = OP_PAGE;
                            oaddr_d = addr_q;
                        end
                    end
                    `CMD_SECT: begin
                        if (byte_q >= `LEN_ADDR && page_ok) begin // [RULE_20]
                            start_d = 1'b1;
                            kind_d = OP_SECT;
                            oaddr_d = addr_q;
                        end
                    end
                    `CMD_BLOCK: begin
                        // The block's lowest sector decides in both decode modes.
                        if (byte_q >= `LEN_ADDR && wel_q
                            && !prot_hit({addr_q[18:16], 4'h0}, bp_q)) begin // [RULE_07]
                            start_d = 1'b1;
                            kind_d = OP_BLOCK;
                            oaddr_d = addr_q;
                        end
                    end
                    `CMD_CHIP_A, `CMD_CHIP_B: begin
                        if (byte_q == `LEN_CMD && wel_q && bp_q == 4'h0) begin // [RULE_08]
                            start_d = 1'b1;
                            kind_d = OP_CHIP; // [RULE_20]
                            oaddr_d = 24'h000000;
                        end
                    end
                    default: begin
                        // Reads and unknown codes change no state here.
                    end
                endcase
            end
        end
        // The busy flag covers the whole internal cycle.
        if (start_d) begin
            busy_d = 1'b1; // [RULE_01]
        end else if (busy_q && op_done_in) begin
            busy_d = 1'b0;
            wel_d = 1'b0; // [RULE_05]
            if (kind_q == OP_STAT) begin
                // Only field and lock change, from the value held since start,
                // so frames ignored while busy cannot alter what is written.
                bp_d = oaddr_q[`ST_BP_HI:`ST_BP_LO]; // [RULE_23]
                lock_d = oaddr_q[`ST_LOCK]; // [RULE_23]
            end
        end
    end
    // Register stage; the protect field resets to its shipped zeros.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            cmd_q <= 8'h00;
            addr_q <= 24'h000000;
            col_q <= 8'h00;
            pend_q <= 8'h00;
            busy_q <= 1'b0;
            wel_q <= 1'b0; // [RULE_06]
            bp_q <= 4'h0; // [RULE_09]
            lock_q <= 1'b0; // [RULE_11]
            sleep_q <= 1'b0;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            start_q <= 1'b0;
            kind_q <= OP_PAGE;
            oaddr_q <= 24'h000000;
            dv_q <= 1'b0;
            db_q <= 8'h00;
            da_q <= 24'h000000;
        end else begin
            shift_q <= shift_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            col_q <= col_d;
            pend_q <= pend_d;
            busy_q <= busy_d;
            wel_q <= wel_d;
            bp_q <= bp_d;
            lock_q <= lock_d;
            sleep_q <= sleep_d;
            so_q <= so_d;
            oe_q <= oe_d;
            start_q <= start_d;
            kind_q <= kind_d;
            oaddr_q <= oaddr_d;
            dv_q <= dv_d;
            db_q <= db_d;
            da_q <= da_d;
        end
    end
    // Outputs come straight from registers.
    assign so_out = so_q;
    assign so_oe_out = oe_q;
    assign op_start_out = start_q;
    assign op_kind_out = kind_q;
    assign op_addr_out = oaddr_q;
    assign data_valid_out = dv_q;
    assign data_out = db_q;
    assign data_addr_out = da_q;
    assign status_out = stat_w;
endmodule
`default_nettype wire

// [sim/spi_host_model.sv]
// Host side of the serial link: drives clock, select and data, samples replies.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    // System clock that paces the link.
    input wire logic clock_in,
    // Serial pins.
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    // A 48 ns link clock; each half period stays above four system clocks.
    localparam real HALF = 24.0;
    // Link edges start half a nanosecond after a rising clock edge and never meet a rising clock edge.
    localparam real SKEW = 0.5;
    // The clock idles low between frames, as in mode 0.
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end
    // Sends the low nbits of d, MSB first; rx keeps the last eight bits seen.
    task automatic xfer(input logic [55:0] d, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        repeat (8) @(posedge clock_in);
        #(SKEW);
        cs_n_out = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_out = d[i];
            #(HALF);
            sck_out = 1'b1;
            // A released line reads as the inverse of what was sent.
            rx = {rx[6:0], so_oe_in ? so_in : ~d[i]};
            #(HALF);
            sck_out = 1'b0;
        end
        #(HALF);
        cs_n_out = 1'b1;
        si_out = ~si_out;
    endtask
endmodule
`default_nettype wire

// [sim/flash_status_wp_checker.sv]
// Concurrent checks on the ports of the status and write-protect block.
`timescale 1ns/10ps
`default_nettype none
module flash_status_wp_checker
    import flash_status_pkg::*;
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Pins and engine side.
    input wire logic cs_n_in,
    input wire logic wp_n_in,
    input wire logic so_oe_out,
    input wire logic op_start_out,
    input wire op_kind_t op_kind_out,
    input wire logic op_done_in,
    input wire logic data_valid_out,
    input wire logic [7:0] status_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Select idle longer than the pin synchroniser and edge detect.
    sequence s_idle; cs_n_in [*8]; endsequence
    // The engine reports the end of a running operation.
    sequence s_done; status_out[0] && op_done_in; endsequence
    property p_res_bit; status_out[6] == 1'b0; endproperty
    a_res_bit: assert property (p_res_bit) else $error("reserved bit set");
    property p_gate; op_start_out |-> $past(status_out[1]) && !$past(status_out[0]); endproperty
    a_gate: assert property (p_gate) else $error("op started unarmed or busy");
    property p_busy; op_start_out |=> status_out[0]; endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_done; s_done |=> status_out[1:0] == 2'b00; endproperty
    a_done: assert property (p_done) else $error("busy or arm left after done");
    property p_chip; op_start_out && op_kind_out == OP_CHIP |-> status_out[5:2] == 4'h0; endproperty
    a_chip: assert property (p_chip) else $error("chip wipe while protected");
    property p_lock; op_start_out && op_kind_out == OP_STAT && status_out[7] |-> wp_n_in; endproperty
    a_lock: assert property (p_lock) else $error("status write while locked");
    property p_idle; s_idle |-> !so_oe_out; endproperty
    a_idle: assert property (p_idle) else $error("output driven while idle");
    property p_dv; data_valid_out |-> status_out[1] && !status_out[0]; endproperty
    a_dv: assert property (p_dv) else $error("data strobe not allowed");
endmodule
bind flash_status_wp flash_status_wp_checker chk_u (.clock_in, .rst_in, .cs_n_in, .wp_n_in,
    .so_oe_out, .op_start_out, .op_kind_out, .op_done_in, .data_valid_out, .status_out);
`default_nettype wire

// [sim/flash_status_wp_tb.sv]
// Self-checking bench for the status and write-protect block.
`timescale 1ns/10ps
`default_nettype none
`include "flash_status_defines.svh"
module flash_status_wp_tb
    import flash_status_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic wp_n_in = 1'b1;
    logic op_done_in = 1'b0;
    logic sck, cs_n, si, so, so_oe, op_start, dv;
    op_kind_t kind;
    logic [23:0] op_addr, d_addr;
    logic [7:0] d_byte, status;
    int fails = 0;
    int n_compared = 0;
    int n_ops = 0;
    int ops_exp = 0;
    logic [31:0] dv_log [$];
    flash_status_wp dut_u (.clock_in(clock_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
        .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe), .op_start_out(op_start),
        .op_kind_out(kind), .op_addr_out(op_addr), .op_done_in(op_done_in),
        .data_valid_out(dv), .data_out(d_byte), .data_addr_out(d_addr), .status_out(status));
    spi_host_model host_u (.clock_in(clock_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si),
        .so_in(so), .so_oe_in(so_oe));
    initial forever #2.5 clock_in = ~clock_in;
    // Started operations and page strobes are logged as they pass.
    always @(posedge clock_in) begin
        if (op_start === 1'b1) n_ops++;
        if (dv === 1'b1) dv_log.push_back({d_byte, d_addr});
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Whole frame, then time for the select edge to act.
    task automatic send(input logic [55:0] d, input int n);
        logic [7:0] r;
        host_u.xfer(d, n, r);
        repeat (8) @(posedge clock_in);
    endtask
    // Checks whether an operation started and, if so, what it was.
    task automatic op(input logic ok, input op_kind_t k, input logic [23:0] a);
        if (ok) ops_exp++;
        check("ops", n_ops, ops_exp);
        if (ok) check("kind", 32'(kind), 32'(k));
        if (ok && k != OP_STAT) check("addr", 32'(op_addr), 32'(a));
    endtask
    task automatic done();
        @(posedge clock_in) op_done_in <= 1'b1;
        @(posedge clock_in) op_done_in <= 1'b0;
        repeat (3) @(posedge clock_in);
    endtask
    task automatic wrstat(input logic ok, input logic [7:0] v);
        send(`CMD_ARM, 8);
        send({`CMD_WR_STAT, v}, 16);
        op(ok, OP_STAT, 24'h0);
        if (ok) done();
    endtask
    // Arm sets the latch, status read repeats, disarm clears.
    task automatic t_arm();
        logic [7:0] r;
        check("status", status, 8'h00);
        send(`CMD_ARM, 8);
        host_u.xfer({`CMD_RD_STAT, 16'h0}, 24, r);
        check("spi status", r, 8'h02);
        send(`CMD_DISARM, 8);
        check("status", status, 8'h00);
    endtask
    // Status write is busy, ignores commands meanwhile, and keeps only lock and field.
    task automatic t_wrstat();
        send(`CMD_ARM, 8);
        send({`CMD_WR_STAT, 8'hc7}, 16);
        op(1'b1, OP_STAT, 24'h0);
        // Refused while busy, and its second byte must not leak into the write.
        send({`CMD_SECT, 24'hff0000}, 32);
        op(1'b0, OP_SECT, 24'h0);
        send(`CMD_DISARM, 8);
        check("busy", status, 8'h03);
        done();
        check("status", status, 8'h84);
    endtask
    // Lock with the pin low refuses writes; pin high or lock clear accepts.
    task automatic t_lock();
        wp_n_in <= 1'b0;
        wrstat(1'b0, 8'h24);
        wp_n_in <= 1'b1;
        wrstat(1'b1, 8'h24);
        wp_n_in <= 1'b0;
        wrstat(1'b1, 8'h04);
        check("status", status, 8'h04);
        wp_n_in <= 1'b1;
    endtask
    // Upper block shielded by field 1; lower sectors by field 9; odd clock count refused.
    task automatic t_protect();
        send(`CMD_ARM, 8);
        send({`CMD_SECT, 24'h070000}, 32);
        op(1'b0, OP_SECT, 24'h0);
        send({`CMD_SECT, 24'h06f000}, 32);
        op(1'b1, OP_SECT, 24'h06f000);
        done();
        send(`CMD_ARM, 8);
        send(`CMD_CHIP_A, 8);
        op(1'b0, OP_CHIP, 24'h0);
        send({`CMD_BLOCK, 24'h070000}, 32);
        op(1'b0, OP_BLOCK, 24'h0);
        send({`CMD_BLOCK, 24'h060000}, 32);
        op(1'b1, OP_BLOCK, 24'h060000);
        done();
        wrstat(1'b1, 8'h24);
        send(`CMD_ARM, 8);
        send({`CMD_SECT, 24'h07d000}, 32);
        op(1'b0, OP_SECT, 24'h0);
        send({`CMD_SECT, 24'h07e000, 1'b0}, 33);
        op(1'b0, OP_SECT, 24'h0);
        send({`CMD_SECT, 24'h07e000}, 32);
        op(1'b1, OP_SECT, 24'h07e000);
        done();
        wrstat(1'b1, 8'h00);
    endtask
    // Both chip wipe codes run with the field clear; sleep blocks arming.
    task automatic t_chip_sleep();
        send(`CMD_ARM, 8);
        send(`CMD_CHIP_A, 8);
        op(1'b1, OP_CHIP, 24'h0);
        done();
        send(`CMD_ARM, 8);
        send(`CMD_CHIP_B, 8);
        op(1'b1, OP_CHIP, 24'h0);
        done();
        send(`CMD_SLEEP, 8);
        send(`CMD_ARM, 8);
        check("asleep", status, 8'h00);
        send(`CMD_WAKE, 8);
        send(`CMD_ARM, 8);
        check("awake", status, 8'h02);
    endtask
    // Page data wraps its column inside the page.
    task automatic t_page();
        dv_log.delete();
        send(`CMD_ARM, 8);
        send({`CMD_PAGE, 24'h0010fe, 24'ha55ac3}, 56);
        op(1'b1, OP_PAGE, 24'h0010fe);
        check("strobes", dv_log.size(), 3);
        check("byte0", dv_log[0], 32'ha50010fe);
        check("byte2", dv_log[2], 32'hc3001000);
        done();
    endtask
    task automatic print_verdict();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Runs are about seven thousand clocks; the watchdog allows over eight times that.
    initial begin
        repeat (60000) @(posedge clock_in);
        fails++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clock_in);
        rst_in <= 1'b0;
        t_arm();
        t_wrstat();
        t_lock();
        t_protect();
        t_chip_sleep();
        t_page();
        print_verdict();
    end
endmodule
`default_nettype wire
